// ### hw/sector_sram_compare.sv
// serial link front end with sector against buffer compare and status read
//
// How it works
// - Opcode 86H on the link starts a sector against buffer compare, not a plain read.
// - Each result bit on the serial output is one when sector and buffer bits match.
// - Stored data never leaves on the output during the compare; result bits do, and ones while no result is waiting.
// - The compare may start at any byte offset given in the byte address field.
// - The byte counter steps by one per compared byte and wraps from 107H to 0H.
// - A differing bit sets the mismatch flag in the status byte once it is shifted out on the link as a result bit.
// - The mismatch flag stays set until the clear compare status command arrives.
// - Only the low eleven or twelve bits of the sector field are decoded.
// - Only the low ten bits of the byte address field are used.
// - A good sector carries C9H in its first byte as shipped.
// - A sector whose first byte is not C9H is reported as unusable once a compare on it fetches byte 0H.
// - A status read returns the busy field and then the eight bit status byte.
`timescale 1ns/1ps
`include "sector_compare_map.svh"
module sector_sram_compare
	import sector_compare_pkg::*;
#(
	parameter int SECTOR_BITS = `SECTOR_BITS,
	parameter int GAP_BITS    = `GAP_BITS,
	parameter int FIFO_DEPTH  = `FIFO_DEPTH
) (
	// system
	input  wire logic                   clk,
	input  wire logic                   arst_n,
	// serial link
	input  wire logic                   sck,
	input  wire logic                   cs_n,
	input  wire logic                   si,
	output logic                        so_out,
	output logic                        so_oe,
	// array and buffer read port
	output logic                        mem_req,
	output logic [SECTOR_BITS-1:0]      mem_sector,
	output logic [9:0]                  mem_byte,
	input  wire logic                   mem_valid,
	input  wire logic [7:0]             mem_sector_data,
	input  wire logic [7:0]             mem_sram_data,
	// status
	output logic                        mismatch_flag,
	output logic                        sector_unusable
);
	localparam int W = 9;

	function automatic logic [9:0] next_byte(input logic [9:0] b);
		return (b >= `LAST_BYTE) ? `FIRST_BYTE : b + 10'h001;
	endfunction : next_byte

	fifo_link_if #(.WIDTH(W)) fl ();

	compare_fifo #(
		.WIDTH(W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.wclk  (clk),
		.wrst_n(arst_n),
		.rclk  (sck),
		.rrst_n(arst_n),
		.lnk   (fl)
	);

	// link domain
	link_state_t                state_reg;
	logic [5:0]                 cnt_reg;
	logic [31:0]                sh_reg;
	logic                       is_cmp_reg;
	logic [2:0]                 bit_reg;
	logic                       tgl_reg;
	logic [SECTOR_BITS-1:0]     sector_reg;
	logic [9:0]                 start_reg;
	logic                       flag_reg;
	logic                       so_reg;
	logic                       oe_reg;
	logic                       frame_rst;
	logic [7:0]                 op_next;
	logic [31:0]                addr_next;
	logic                       head_ok;
	logic                       head_stale;
	logic                       cur_bit;
	logic                       op_done;
	logic                       addr_done;
	logic [7:0]                 status_byte_field;
	logic [2:0]                 stat_idx;
	logic                       so_next;

	assign frame_rst = cs_n | ~arst_n;
	assign op_next   = {sh_reg[6:0], si};
	assign addr_next = {sh_reg[30:0], si};
	assign op_done   = state_reg == LS_OPCODE && cnt_reg == 6'(`OPCODE_BITS - 1);
	assign addr_done = state_reg == LS_ADDR && cnt_reg == 6'(`ADDR_BITS - 1);
	assign head_ok    = fl.r_valid && fl.r_data[8] == tgl_reg;
	assign head_stale = fl.r_valid && !head_ok;
	assign cur_bit    = fl.r_data[3'd7 - bit_reg];
	// stale bytes of an earlier frame are dropped, a byte is freed after its eighth bit
	assign fl.r_ready = ((state_reg == LS_CMP || state_reg == LS_GAP) && head_stale) ||
		(state_reg == LS_CMP && head_ok && bit_reg == 3'd7);

	always_comb begin
		status_byte_field = 8'h00;
		status_byte_field[`STATUS_READY_BIT] = 1'b1;
		status_byte_field[`STATUS_FLAG_BIT]  = flag_reg;
	end

	assign stat_idx = 3'(6'(`RB_BITS + `STATUS_BITS - 1) - cnt_reg);

	always_comb begin
		so_next = 1'b1;
		if (state_reg == LS_CMP) begin
			so_next = head_ok ? cur_bit : 1'b1;
		end else if (state_reg == LS_STAT && cnt_reg >= 6'(`RB_BITS)) begin
			so_next = status_byte_field[stat_idx];
		end
	end

	// command sequencer, cleared whenever the chip is deselected
	always_ff @(posedge sck or posedge frame_rst) begin
		if (frame_rst) begin
			state_reg  <= LS_OPCODE;
			cnt_reg    <= 6'h00;
			sh_reg     <= 32'h0000_0000;
			is_cmp_reg <= 1'b0;
			bit_reg    <= 3'h0;
		end else begin
			case (state_reg)
				LS_OPCODE: begin
					sh_reg  <= addr_next;
					cnt_reg <= cnt_reg + 6'h01;
					if (op_done) begin
						cnt_reg <= 6'h00;
						if (op_next == `OP_COMPARE) begin
							state_reg  <= LS_ADDR;
							is_cmp_reg <= 1'b1;
						end else if (op_next == `OP_STATUS) begin
							state_reg <= LS_ADDR;
						end else begin
							state_reg <= LS_IGNORE;
						end
					end
				end
				LS_ADDR: begin
					sh_reg  <= addr_next;
					cnt_reg <= cnt_reg + 6'h01;
					if (addr_done) begin
						cnt_reg   <= 6'h00;
						state_reg <= is_cmp_reg ? LS_GAP : LS_STAT;
					end
				end
				LS_GAP: begin
					cnt_reg <= cnt_reg + 6'h01;
					if (cnt_reg == 6'(GAP_BITS - 1)) begin
						state_reg <= LS_CMP;
					end
				end
				LS_CMP: begin
					if (head_ok) begin
						bit_reg <= bit_reg + 3'h1;
					end
				end
				LS_STAT: begin
					cnt_reg <= cnt_reg + 6'h01;
					if (cnt_reg == 6'(`RB_BITS + `STATUS_BITS - 1)) begin
						state_reg <= LS_IGNORE;
					end
				end
				LS_IGNORE: begin
					state_reg <= LS_IGNORE;
				end
				default: begin
					state_reg <= LS_IGNORE;
				end
			endcase
		end
	end

	// compare start handed to the fetch side, held stable until the next start
	always_ff @(posedge sck or negedge arst_n) begin
		if (!arst_n) begin
			tgl_reg    <= 1'b0;
			sector_reg <= '0;
			start_reg  <= 10'h000;
		end else if (addr_done && is_cmp_reg) begin
			sector_reg <= addr_next[16 +: SECTOR_BITS];
			start_reg  <= addr_next[9:0];
			tgl_reg    <= ~tgl_reg;
		end
	end

	// sticky mismatch, set wins over clear
	always_ff @(posedge sck or negedge arst_n) begin
		if (!arst_n) begin
			flag_reg <= 1'b0;
		end else if (state_reg == LS_CMP && head_ok && !cur_bit) begin
			flag_reg <= 1'b1;
		end else if (op_done && op_next == `OP_CLEAR_CMP) begin
			flag_reg <= 1'b0;
		end
	end

	// output launched on the falling edge, sampled by the host on the rising one
	always_ff @(negedge sck or posedge frame_rst) begin
		if (frame_rst) begin
			so_reg <= 1'b0;
			oe_reg <= 1'b0;
		end else begin
			so_reg <= so_next;
			oe_reg <= state_reg == LS_CMP || state_reg == LS_STAT;
		end
	end

	assign so_out = so_reg;
	assign so_oe  = oe_reg;

	// system domain
	fetch_state_t               fstate_reg;
	logic [2:0]                 tsync_reg;
	logic [2:0]                 csync_reg;
	logic [2:0]                 msync_reg;
	logic                       mflag_reg;
	logic                       seen_reg;
	logic                       cs_hi_reg;
	logic                       ftag_reg;
	logic [7:0]                 res_reg;
	logic                       req_reg;
	logic [SECTOR_BITS-1:0]     msec_reg;
	logic [9:0]                 mbyte_reg;
	logic                       bad_reg;
	logic                       start;

	assign start = tsync_reg[1] == tsync_reg[2] && tsync_reg[2] != seen_reg;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tsync_reg <= 3'h0;
			csync_reg <= 3'h7;
			msync_reg <= 3'h0;
			mflag_reg <= 1'b0;
			cs_hi_reg <= 1'b1;
		end else begin
			tsync_reg <= {tsync_reg[1:0], tgl_reg};
			csync_reg <= {csync_reg[1:0], cs_n};
			msync_reg <= {msync_reg[1:0], flag_reg};
			// flag taken once the last two stages agree
			if (msync_reg[1] == msync_reg[2]) begin
				mflag_reg <= msync_reg[2];
			end
			if (csync_reg[1] == csync_reg[2]) begin
				cs_hi_reg <= csync_reg[2];
			end
		end
	end

	assign fl.w_valid = fstate_reg == FS_PUSH && !cs_hi_reg;
	assign fl.w_data  = {ftag_reg, res_reg};

	// fetch engine: one byte pair per step, xnor pushed toward the link
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fstate_reg <= FS_IDLE;
			seen_reg   <= 1'b0;
			ftag_reg   <= 1'b0;
			res_reg    <= 8'h00;
			req_reg    <= 1'b0;
			msec_reg   <= '0;
			mbyte_reg  <= 10'h000;
		end else begin
			case (fstate_reg)
				FS_IDLE: begin
					if (start) begin
						seen_reg   <= tsync_reg[2];
						ftag_reg   <= tsync_reg[2];
						msec_reg   <= sector_reg;
						mbyte_reg  <= start_reg;
						req_reg    <= 1'b1;
						fstate_reg <= FS_READ;
					end
				end
				FS_READ: begin
					if (cs_hi_reg) begin
						req_reg    <= 1'b0;
						fstate_reg <= FS_IDLE;
					end else if (mem_valid) begin
						res_reg    <= ~(mem_sector_data ^ mem_sram_data);
						req_reg    <= 1'b0;
						fstate_reg <= FS_PUSH;
					end
				end
				FS_PUSH: begin
					if (cs_hi_reg) begin
						fstate_reg <= FS_IDLE;
					end else if (fl.w_ready) begin
						mbyte_reg  <= next_byte(mbyte_reg);
						req_reg    <= 1'b1;
						fstate_reg <= FS_READ;
					end
				end
				default: begin
					fstate_reg <= FS_IDLE;
				end
			endcase
		end
	end

	// first byte of the sector checked against the factory tag
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bad_reg <= 1'b0;
		end else if (fstate_reg == FS_IDLE && start) begin
			bad_reg <= 1'b0;
		end else if (fstate_reg == FS_READ && mem_valid && !cs_hi_reg &&
			mbyte_reg == `FIRST_BYTE) begin
			bad_reg <= mem_sector_data != `TAG_SYNC;
		end
	end

	assign mem_req         = req_reg;
	assign mem_sector      = msec_reg;
	assign mem_byte        = mbyte_reg;
	assign mismatch_flag   = mflag_reg;
	assign sector_unusable = bad_reg;
endmodule : sector_sram_compare

// ### hw/sector_compare_map.svh
// offsets, field positions, opcodes and counts for the sector compare block
`ifndef SECTOR_COMPARE_MAP_SVH
`define SECTOR_COMPARE_MAP_SVH
`define OP_COMPARE      8'h86
`define OP_STATUS       8'h83
`define OP_CLEAR_CMP    8'h8E
`define FIRST_BYTE      10'h000
`define LAST_BYTE       10'h107
`define TAG_SYNC        8'hC9
`define OPCODE_BITS     8
`define ADDR_BITS       32
`define RB_BITS         16
`define STATUS_BITS     8
`define GAP_BITS        16
`define SECTOR_BITS     12
`define STATUS_READY_BIT 0
`define STATUS_FLAG_BIT  1
`define FIFO_DEPTH      4
`endif

// ### hw/sector_compare_pkg.sv
// state types for the sector compare block
package sector_compare_pkg;
	typedef enum logic [2:0] {
		LS_OPCODE = 3'b000,
		LS_ADDR   = 3'b001,
		LS_GAP    = 3'b011,
		LS_CMP    = 3'b010,
		LS_STAT   = 3'b110,
		LS_IGNORE = 3'b100
	} link_state_t;
	typedef enum logic [1:0] {
		FS_IDLE = 2'b00,
		FS_READ = 2'b01,
		FS_PUSH = 2'b11
	} fetch_state_t;
endpackage : sector_compare_pkg

// ### hw/fifo_link_if.sv
// valid/ready carrier between the fetch side, the fifo and the link side
`timescale 1ns/1ps
interface fifo_link_if #(parameter int WIDTH = 9);
	logic             w_valid;
	logic             w_ready;
	logic [WIDTH-1:0] w_data;
	logic             r_valid;
	logic             r_ready;
	logic [WIDTH-1:0] r_data;
	modport fifo (input w_valid, w_data, r_ready, output w_ready, r_valid, r_data);
	modport user (output w_valid, w_data, r_ready, input w_ready, r_valid, r_data);
endinterface : fifo_link_if

// ### hw/compare_fifo.sv
// dual clock fifo with gray coded pointers
`timescale 1ns/1ps
module compare_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4
) (
	// write side
	input  wire logic wclk,
	input  wire logic wrst_n,
	// read side
	input  wire logic rclk,
	input  wire logic rrst_n,
	// data
	fifo_link_if.fifo lnk
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] ONE = {{AW{1'b0}}, 1'b1};

	function automatic logic [AW:0] to_gray(input logic [AW:0] b);
		return b ^ (b >> 1);
	endfunction : to_gray

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wbin_reg;
	logic [AW:0]      wgray_reg;
	logic [AW:0]      rbin_reg;
	logic [AW:0]      rgray_reg;
	logic [AW:0]      rg1_reg;
	logic [AW:0]      rg2_reg;
	logic [AW:0]      wg1_reg;
	logic [AW:0]      wg2_reg;
	logic             full;
	logic             empty;
	logic             push;
	logic             pop;

	assign full  = wgray_reg == {~rg2_reg[AW:AW-1], rg2_reg[AW-2:0]};
	assign empty = rgray_reg == wg2_reg;
	assign push  = lnk.w_valid & ~full;
	assign pop   = lnk.r_ready & ~empty;
	assign lnk.w_ready = ~full;
	assign lnk.r_valid = ~empty;
	assign lnk.r_data  = mem[rbin_reg[AW-1:0]];

	always_ff @(posedge wclk) begin
		if (push) begin
			mem[wbin_reg[AW-1:0]] <= lnk.w_data;
		end
	end

	always_ff @(posedge wclk or negedge wrst_n) begin
		if (!wrst_n) begin
			wbin_reg  <= '0;
			wgray_reg <= '0;
			rg1_reg   <= '0;
			rg2_reg   <= '0;
		end else begin
			rg1_reg <= rgray_reg;
			rg2_reg <= rg1_reg;
			if (push) begin
				wbin_reg  <= wbin_reg + ONE;
				wgray_reg <= to_gray(wbin_reg + ONE);
			end
		end
	end

	always_ff @(posedge rclk or negedge rrst_n) begin
		if (!rrst_n) begin
			rbin_reg  <= '0;
			rgray_reg <= '0;
			wg1_reg   <= '0;
			wg2_reg   <= '0;
		end else begin
			wg1_reg <= wgray_reg;
			wg2_reg <= wg1_reg;
			if (pop) begin
				rbin_reg  <= rbin_reg + ONE;
				rgray_reg <= to_gray(rbin_reg + ONE);
			end
		end
	end
endmodule : compare_fifo

// ### verification/sector_sram_compare_props.sv
// port assertions and covers for the sector compare block
`timescale 1ns/1ps
module sector_sram_compare_props #(
	parameter int GAP_BITS = 16
) (
	// system
	input wire logic       clk,
	input wire logic       arst_n,
	// link
	input wire logic       sck,
	input wire logic       cs_n,
	input wire logic       si,
	input wire logic       so_out,
	input wire logic       so_oe,
	// memory and status
	input wire logic       mem_req,
	input wire logic [9:0] mem_byte,
	input wire logic       mem_valid,
	input wire logic       mismatch_flag
);
	localparam int RES = 40 + GAP_BITS;
	logic [7:0] rise_reg;
	logic [7:0] op_reg;
	logic [9:0] exp_reg;
	logic       seen_reg;
	logic [3:0] zero_reg;
	// rises since select
	always_ff @(posedge sck or posedge cs_n) begin
		if (cs_n) rise_reg <= 8'h00;
		else if (rise_reg != 8'hFF) rise_reg <= rise_reg + 8'h01;
	end
	always_ff @(posedge sck or posedge cs_n) begin
		if (cs_n) op_reg <= 8'h00;
		else if (rise_reg < 8'h08) op_reg <= {op_reg[6:0], si};
	end
	// offset due after each fetch; cleared by a deselect
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			exp_reg  <= 10'h000;
			seen_reg <= 1'b1;
		end else if (mem_req && mem_valid) begin
			exp_reg  <= (mem_byte >= 10'h107) ? 10'h000 : mem_byte + 10'h001;
			seen_reg <= 1'b0;
		end else if (cs_n) begin
			seen_reg <= 1'b1;
		end
	end
	// cycles since a low bit was driven
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) zero_reg <= 4'hF;
		else if (so_oe && !so_out) zero_reg <= 4'h0;
		else if (zero_reg != 4'hF) zero_reg <= zero_reg + 4'h1;
	end
	oe_deselect_a: assert property (@(posedge clk) disable iff (!arst_n)
		cs_n && $past(cs_n) |-> !so_oe) else $error("output driven while deselected");
	byte_step_a: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(mem_req) && !seen_reg |-> mem_byte == exp_reg) else $error("offset did not step");
	flag_cause_a: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(mismatch_flag) |-> zero_reg < 4'h8) else $error("flag set without low bit");
	flag_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
		$fell(mismatch_flag) |-> !cs_n || !$past(cs_n, 4)) else $error("flag dropped idle");
	oe_early_a: assert property (@(posedge sck) disable iff (!arst_n || cs_n)
		rise_reg < 8'h28 |-> !so_oe) else $error("output driven in header");
	cmp_gap_a: assert property (@(posedge sck) disable iff (!arst_n || cs_n)
		op_reg == 8'h86 && rise_reg < RES |-> !so_oe) else $error("output driven in gap");
	cmp_oe_a: assert property (@(posedge sck) disable iff (!arst_n || cs_n)
		op_reg == 8'h86 && rise_reg >= RES |-> so_oe) else $error("result bit not driven");
	stat_ones_a: assert property (@(posedge sck) disable iff (!arst_n || cs_n)
		op_reg == 8'h83 && rise_reg >= 8'h28 && rise_reg < 8'h38 |-> so_oe && so_out)
		else $error("ready field not ones");
	stat_flag_a: assert property (@(posedge sck) disable iff (!arst_n || cs_n)
		op_reg == 8'h83 && rise_reg == 8'h3E |-> so_out == mismatch_flag)
		else $error("status flag bit wrong");
	cmp_run_c: cover property (@(posedge sck) op_reg == 8'h86 && rise_reg == RES);
	flag_set_c: cover property (@(posedge clk) $rose(mismatch_flag));
	flag_clr_c: cover property (@(posedge clk) $fell(mismatch_flag));
endmodule : sector_sram_compare_props
bind sector_sram_compare sector_sram_compare_props #(
	.GAP_BITS(GAP_BITS)
) u_sector_sram_compare_props (
	.clk          (clk),
	.arst_n       (arst_n),
	.sck          (sck),
	.cs_n         (cs_n),
	.si           (si),
	.so_out       (so_out),
	.so_oe        (so_oe),
	.mem_req      (mem_req),
	.mem_byte     (mem_byte),
	.mem_valid    (mem_valid),
	.mismatch_flag(mismatch_flag)
);

// ### verification/link_host.sv
// serial link master model that frames commands and samples results
`timescale 1ns/1ps
module link_host (
	// link
	output logic      sck,
	output logic      cs_n,
	output logic      si,
	input  wire logic so_out,
	input  wire logic so_oe
);
	initial begin
		sck  = 1'b0;
		cs_n = 1'b1;
		si   = 1'b0;
	end
	// header, dummy clocks, then n bits taken on rising edges
	task automatic frame(input logic [39:0] hdr, input int skip, input int n,
		output logic [63:0] rd, output logic oe);
		int i;
		rd = '0;
		oe = 1'b0;
		#7.3 cs_n = 1'b0;
		#85;
		for (i = 0; i < 40 + skip + n; i++) begin
			si = (i < 40) ? hdr[39 - i] : 1'b0;
			#15 sck = 1'b1;
			oe = oe | so_oe;
			if (i >= 40 + skip) rd = {rd[62:0], so_out};
			#15 sck = 1'b0;
		end
		#100 cs_n = 1'b1;
		si = ~si;
		#200;
	endtask : frame
endmodule : link_host

// ### verification/sector_sram_compare_tb.sv
// self-checking bench for the sector compare block
`timescale 1ns/1ps
module sector_sram_compare_tb;
	logic        clk, arst_n, sck, cs_n, si, so_out, so_oe;
	logic        mem_req, mem_valid, mismatch_flag, sector_unusable;
	logic [11:0] mem_sector, last_sec;
	logic [9:0]  mem_byte, bad_off;
	logic [7:0]  mem_sector_data, mem_sram_data, tag_val, bad_mask, b;
	logic [9:0]  offs[$];
	logic [63:0] rd;
	logic        oe;
	int          lat, wait_cnt, err_total, n_tests;
	sector_sram_compare u_sector_sram_compare (
		.clk            (clk),
		.arst_n         (arst_n),
		.sck            (sck),
		.cs_n           (cs_n),
		.si             (si),
		.so_out         (so_out),
		.so_oe          (so_oe),
		.mem_req        (mem_req),
		.mem_sector     (mem_sector),
		.mem_byte       (mem_byte),
		.mem_valid      (mem_valid),
		.mem_sector_data(mem_sector_data),
		.mem_sram_data  (mem_sram_data),
		.mismatch_flag  (mismatch_flag),
		.sector_unusable(sector_unusable)
	);
	link_host u_link_host (
		.sck   (sck),
		.cs_n  (cs_n),
		.si    (si),
		.so_out(so_out),
		.so_oe (so_oe)
	);
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// array and buffer model; lines wander while no byte is offered
	always @(negedge clk) begin
		b = (mem_byte == 10'h000) ? tag_val : mem_byte[7:0] ^ mem_sector[7:0];
		wait_cnt <= (mem_req && !mem_valid) ? wait_cnt + 1 : 0;
		if (mem_req && !mem_valid && wait_cnt >= lat) begin
			mem_valid <= 1'b1;
			mem_sector_data <= b;
			mem_sram_data <= b ^ ((mem_byte == bad_off) ? bad_mask : 8'h00);
			offs.push_back(mem_byte);
			last_sec <= mem_sector;
		end else begin
			mem_valid <= 1'b0;
			mem_sector_data <= ~mem_sector_data;
			mem_sram_data <= ~mem_sram_data;
		end
	end
	task automatic chk(input logic [63:0] exp, input logic [63:0] got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t exp %h got %h", $time, exp, got);
		end
	endtask : chk
	task automatic t_equal;
		offs = {};
		u_link_host.frame({8'h86, 16'hF123, 16'hFD06}, 16, 24, rd, oe);
		chk(64'hFF_FFFF, rd);
		chk(64'h106, {54'h0, offs[0]});
		chk(64'h000, {54'h0, offs[2]});
		chk(64'h123, {52'h0, last_sec});
		chk(64'h0, {62'h0, mismatch_flag, sector_unusable});
		$display("t_equal done");
	endtask : t_equal
	task automatic t_diff;
		tag_val = 8'h55;
		bad_off = 10'h107;
		offs = {};
		u_link_host.frame({8'h86, 32'h0000_0107}, 16, 16, rd, oe);
		chk(64'hDEFF, rd);
		chk(64'h000, {54'h0, offs[1]});
		chk(64'h3, {62'h0, mismatch_flag, sector_unusable});
		$display("t_diff done");
	endtask : t_diff
	task automatic t_sticky;
		tag_val = 8'hC9;
		bad_off = 10'h3FF;
		u_link_host.frame({8'h86, 32'h0}, 16, 8, rd, oe);
		chk(64'hFF, rd);
		chk(64'h2, {62'h0, mismatch_flag, sector_unusable});
		u_link_host.frame({8'h83, 32'h0}, 0, 24, rd, oe);
		chk(64'hFF_FF03, rd);
		u_link_host.frame({8'h8E, 32'h0}, 0, 0, rd, oe);
		u_link_host.frame({8'h83, 32'h0}, 0, 24, rd, oe);
		chk(64'hFF_FF01, rd);
		$display("t_sticky done");
	endtask : t_sticky
	task automatic t_slow;
		lat = 40;
		u_link_host.frame({8'h86, 32'h0000_0010}, 16, 24, rd, oe);
		lat = 1;
		chk(64'hFF_FFFF, rd);
		chk(64'h0, {63'h0, mismatch_flag});
		$display("t_slow done");
	endtask : t_slow
	task automatic t_unknown;
		u_link_host.frame({8'h3A, 32'h0}, 16, 8, rd, oe);
		chk(64'h0, {63'h0, oe});
		$display("t_unknown done");
	endtask : t_unknown
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : summarize
	initial begin
		#400000;
		err_total++;
		$display("watchdog expired");
		summarize;
	end
	initial begin
		arst_n = 1'b0;
		mem_valid = 1'b0;
		mem_sector_data = 8'h00;
		mem_sram_data = 8'h00;
		tag_val = 8'hC9;
		bad_off = 10'h3FF;
		bad_mask = 8'h21;
		lat = 1;
		wait_cnt = 0;
		err_total = 0;
		n_tests = 0;
		repeat (16) @(posedge clk);
		@(negedge clk) arst_n = 1'b1;
		repeat (20) @(negedge clk);
		t_equal;
		t_diff;
		t_sticky;
		t_slow;
		t_unknown;
		summarize;
	end
endmodule : sector_sram_compare_tb
